// file: core/opi_i2c_host.sv
// Two-wire bus controller for the pulled oscillator, AXI4-Lite slave.
// Assumes open-drain pins with pull-ups outside and one target on the bus.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`include "opi_defines.svh"

module opi_i2c_host (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [7:0] awaddr,
  input wire awvalid,
  output logic awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire rready,
  input wire scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire sda_i,
  output logic sda_o,
  output logic sda_oe
);

  localparam logic [2:0] QTR_LAST = 3'(`OPI_QTR_CYC - 1);
  localparam logic [9:0] SETTLE_LAST = 10'(`OPI_SETTLE_CYC - 1);

  function automatic logic [31:0] apply_strb(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a == `OPI_OFF_CTRL) || (a == `OPI_OFF_ADDR) ||
      (a == `OPI_OFF_WDATA) || (a == `OPI_OFF_STATUS) ||
      (a == `OPI_OFF_RDATA) || (a == `OPI_OFF_RANGE);
  endfunction

  // Byte sequence of one transfer, indexed by step
  function automatic opi_pkg::opi_step_type plan_step(
    input logic [2:0] s,
    input opi_pkg::opi_req_type r
  );
    opi_pkg::opi_step_type p;
    p.op = opi_pkg::OPI_OP_TX;
    p.tx = 8'h00;
    unique case (s)
      3'h0: p.op = opi_pkg::OPI_OP_START;
      // address phase always in write direction
      3'h1: p.tx = {r.dev, `OPI_DIR_WRITE};
      3'h2: p.tx = r.regad;
      3'h3: begin
        if (r.rd) begin
          p.op = opi_pkg::OPI_OP_START;
        end else begin
          p.tx = r.data[15:8];
        end
      end
      3'h4: begin
        if (r.rd) begin
          p.tx = {r.dev, `OPI_DIR_READ};
        end else begin
          p.tx = r.data[7:0];
        end
      end
      3'h5: begin
        if (r.rd) begin
          p.op = opi_pkg::OPI_OP_RX;
        end else if (r.two) begin
          p.tx = r.data[31:24];
        end else begin
          p.op = opi_pkg::OPI_OP_STOP;
        end
      end
      3'h6: begin
        if (r.rd) begin
          p.op = opi_pkg::OPI_OP_RX;
        end else begin
          p.tx = r.data[23:16];
        end
      end
      3'h7: p.op = opi_pkg::OPI_OP_STOP;
    endcase
    return p;
  endfunction

  // pull range code to ppm times 100
  function automatic logic [18:0] range_ppm(input logic [3:0] c);
    logic [18:0] v;
    v = 19'h00000;
    unique case (c)
      4'h0: v = 19'h00271;
      4'h1: v = 19'h003E8;
      4'h2: v = 19'h004E2;
      4'h3: v = 19'h009C4;
      4'h4: v = 19'h01388;
      4'h5: v = 19'h01F40;
      4'h6: v = 19'h02710;
      4'h7: v = 19'h030D4;
      4'h8: v = 19'h03A98;
      4'h9: v = 19'h04E20;
      4'hA: v = 19'h09C40;
      4'hB: v = 19'h0EA60;
      4'hC: v = 19'h13880;
      4'hD: v = 19'h1D4C0;
      4'hE: v = 19'h27100;
      4'hF: v = 19'h4E200;
    endcase
    return v;
  endfunction

  logic aw_full_q, w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic rd_q, two_q;
  logic [31:0] addr_q, wreg_q;
  logic [15:0] rword_q;
  logic done_q, nack_q;
  logic [9:0] settle_q;
  logic settling_q;
  opi_pkg::opi_state_type state_q;
  opi_pkg::opi_req_type req_q;
  logic [2:0] tick_q, step_q;
  logic [1:0] qtr_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic is_rx_q;

  wire opi_pkg::opi_pins_type pins_raw;
  wire opi_pkg::opi_pins_type pins_s;
  assign pins_raw = {scl_i, sda_i};

  opi_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin_in(pins_raw),
    .pin_sync(pins_s)
  );

  wire busy = (state_q != opi_pkg::OPI_ST_IDLE);
  wire aw_hs = awvalid & awready;
  wire w_hs = wvalid & wready;
  wire ar_hs = arvalid & arready;
  wire do_wr = aw_full_q & w_full_q & ~bvalid;
  wire wr_ctrl = do_wr & (awaddr_q == `OPI_OFF_CTRL);
  wire wr_addr = do_wr & (awaddr_q == `OPI_OFF_ADDR);
  wire wr_wdata = do_wr & (awaddr_q == `OPI_OFF_WDATA);
  wire [31:0] ctrl_rd = {29'h0, two_q, rd_q, 1'b0};
  wire [31:0] ctrl_new = apply_strb(ctrl_rd, wdata_q, wstrb_q);
  wire go = wr_ctrl & ctrl_new[`OPI_CTRL_GO] & ~busy;
  wire [31:0] stat_rd = {28'h0, settling_q, nack_q, done_q, busy};
  wire [31:0] range_rd = {13'h0, range_ppm(rword_q[3:0])};
  wire [31:0] rd_mux =
    (araddr == `OPI_OFF_CTRL) ? ctrl_rd :
    (araddr == `OPI_OFF_ADDR) ? addr_q :
    (araddr == `OPI_OFF_WDATA) ? wreg_q :
    (araddr == `OPI_OFF_STATUS) ? stat_rd :
    (araddr == `OPI_OFF_RDATA) ? {16'h0, rword_q} :
    (araddr == `OPI_OFF_RANGE) ? range_rd : 32'h0;

  wire timed = (state_q == opi_pkg::OPI_ST_START) |
    (state_q == opi_pkg::OPI_ST_BIT) | (state_q == opi_pkg::OPI_ST_STOP);
  // Clock held low by the far end stretches the high quarter
  wire scl_stall = ~scl_oe & ~pins_s.scl;
  wire qtr_end = timed & (tick_q == QTR_LAST) & ~scl_stall;
  wire last_q = qtr_end & (qtr_q == 2'h3);
  wire ack_bit = (bit_q == 4'h8);
  wire opi_pkg::opi_step_type cur = plan_step(step_q, req_q);
  // writes reaching the high part start the settle wait
  wire hits_high = ~req_q.rd & ((req_q.regad == `OPI_REG_WORD_HIGH) |
    ((req_q.regad == `OPI_REG_WORD_LOW) & req_q.two));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `OPI_RESP_OKAY;
    end else if (ce) begin
      if (aw_hs) begin
        awaddr_q <= awaddr;
        aw_full_q <= 1'b1;
        awready <= 1'b0;
      end else if (!aw_full_q && !bvalid) begin
        awready <= 1'b1;
      end
      if (w_hs) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        w_full_q <= 1'b1;
        wready <= 1'b0;
      end else if (!w_full_q && !bvalid) begin
        wready <= 1'b1;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(awaddr_q) ? `OPI_RESP_OKAY : `OPI_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `OPI_RESP_OKAY;
    end else if (ce) begin
      if (ar_hs) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= mapped(araddr) ? `OPI_RESP_OKAY : `OPI_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end else if (!rvalid) begin
        arready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_q <= 1'(`OPI_CTRL_RST >> `OPI_CTRL_RD);
      two_q <= 1'(`OPI_CTRL_RST >> `OPI_CTRL_TWO);
      addr_q <= `OPI_ADDR_RST;
      wreg_q <= `OPI_WDATA_RST;
    end else if (ce) begin
      if (wr_ctrl) begin
        rd_q <= ctrl_new[`OPI_CTRL_RD];
        two_q <= ctrl_new[`OPI_CTRL_TWO];
      end
      if (wr_addr) begin
        addr_q <= apply_strb(addr_q, wdata_q, wstrb_q) & 32'h0000_FF7F;
      end
      if (wr_wdata) begin
        wreg_q <= apply_strb(wreg_q, wdata_q, wstrb_q);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_q <= 3'h0;
      qtr_q <= 2'h0;
    end else if (ce) begin
      if (!timed || qtr_end) begin
        tick_q <= 3'h0;
      end else if (tick_q != QTR_LAST) begin
        tick_q <= tick_q + 3'h1;
      end
      if (!timed) begin
        qtr_q <= 2'h0;
      end else if (qtr_end) begin
        qtr_q <= qtr_q + 2'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= opi_pkg::OPI_ST_IDLE;
      req_q <= '0;
      step_q <= 3'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      is_rx_q <= 1'b0;
      rword_q <= 16'h0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end else if (ce) begin
      unique case (state_q)
        opi_pkg::OPI_ST_IDLE: begin
          if (go) begin
            state_q <= opi_pkg::OPI_ST_LOAD;
            step_q <= 3'h0;
            done_q <= 1'b0;
            nack_q <= 1'b0;
            req_q <= {ctrl_new[`OPI_CTRL_RD], ctrl_new[`OPI_CTRL_TWO],
              addr_q[6:0], addr_q[15:8], wreg_q};
          end
        end
        opi_pkg::OPI_ST_LOAD: begin
          bit_q <= 4'h0;
          sh_q <= cur.tx;
          is_rx_q <= (cur.op == opi_pkg::OPI_OP_RX);
          unique case (cur.op)
            opi_pkg::OPI_OP_START: state_q <= opi_pkg::OPI_ST_START;
            opi_pkg::OPI_OP_TX: state_q <= opi_pkg::OPI_ST_BIT;
            opi_pkg::OPI_OP_RX: state_q <= opi_pkg::OPI_ST_BIT;
            opi_pkg::OPI_OP_STOP: state_q <= opi_pkg::OPI_ST_STOP;
          endcase
        end
        opi_pkg::OPI_ST_START: begin
          if (last_q) begin
            step_q <= step_q + 3'h1;
            state_q <= opi_pkg::OPI_ST_LOAD;
          end
        end
        opi_pkg::OPI_ST_BIT: begin
          if (last_q) begin
            if (!ack_bit) begin
              // shift out and in, MSB first
              sh_q <= {sh_q[6:0], pins_s.sda};
              bit_q <= bit_q + 4'h1;
            end else if (!is_rx_q && pins_s.sda) begin
              nack_q <= 1'b1;
              state_q <= opi_pkg::OPI_ST_STOP;
            end else begin
              step_q <= step_q + 3'h1;
              state_q <= opi_pkg::OPI_ST_LOAD;
              if (is_rx_q && step_q == 3'h5) begin
                rword_q[15:8] <= sh_q;
              end
              if (is_rx_q && step_q == 3'h6) begin
                rword_q[7:0] <= sh_q;
              end
            end
          end
        end
        opi_pkg::OPI_ST_STOP: begin
          if (last_q) begin
            state_q <= opi_pkg::OPI_ST_IDLE;
            done_q <= 1'b1;
          end
        end
        default: state_q <= opi_pkg::OPI_ST_IDLE;
      endcase
    end
  end

  // data moves a quarter after clock falls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ce && qtr_end) begin
      unique case (state_q)
        opi_pkg::OPI_ST_START: begin
          // release data, raise clock, then drop data
          unique case (qtr_q)
            2'h0: sda_oe <= 1'b0;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b1;
            2'h3: scl_oe <= 1'b1;
          endcase
        end
        opi_pkg::OPI_ST_BIT: begin
          unique case (qtr_q)
            2'h0: begin
              if (ack_bit) begin
                // release on ninth clock when sending
                sda_oe <= is_rx_q;
              end else begin
                sda_oe <= ~is_rx_q & ~sh_q[7];
              end
            end
            2'h1: scl_oe <= 1'b0;
            2'h2: scl_oe <= 1'b0;
            2'h3: scl_oe <= 1'b1;
          endcase
        end
        opi_pkg::OPI_ST_STOP: begin
          unique case (qtr_q)
            2'h0: sda_oe <= 1'b1;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b0;
            2'h3: sda_oe <= 1'b0;
          endcase
        end
        default: sda_oe <= sda_oe;
      endcase
    end
  end

  // Open-drain pins only ever pull low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else if (ce) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // settle wait after a new control word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_q <= 10'h000;
      settling_q <= 1'b0;
    end else if (ce) begin
      if (state_q == opi_pkg::OPI_ST_STOP && last_q && hits_high &&
          !nack_q) begin
        settle_q <= 10'h000;
        settling_q <= 1'b1;
      end else if (settling_q) begin
        if (settle_q == SETTLE_LAST) begin
          settling_q <= 1'b0;
        end else begin
          settle_q <= settle_q + 10'h001;
        end
      end
    end
  end

endmodule // opi_i2c_host

// file: core/opi_sync.sv
// Two-flop synchroniser for the bus clock and data lines.
// Assumes the lines idle high, so reset loads ones.
module opi_sync (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input opi_pkg::opi_pins_type pin_in,
  output opi_pkg::opi_pins_type pin_sync
);

  opi_pkg::opi_pins_type meta_q;
  opi_pkg::opi_pins_type sync_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
    end else if (ce) begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_sync = sync_q;

endmodule // opi_sync

// file: dv/opi_dev_model.sv
// Behavioural model of the pulled oscillator's two-wire target.
// Assumes wired lines with pull-ups; it only ever pulls data low.
module opi_dev_model #(
  parameter logic [6:0] DEV = 7'h60,
  parameter logic [3:0] RANGE0 = 4'h5
) (
  input wire scl,
  input wire sda,
  output logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] w0, tw;
  logic [10:0] w1;
  logic [25:0] word;
  logic [3:0] rng;
  logic [7:0] ad, sh, hb, tb;
  logic act, tx, rdm, hib, mack;
  int cnt, ph;
  function automatic logic [15:0] rv(input logic [7:0] a);
    case (a)
      8'h00: return w0;
      8'h01: return {5'h00, w1};
      8'h02: return {12'h000, rng};
      default: return 16'h0000;
    endcase
  endfunction
  initial begin
    sda_oe = 1'b0;
    act = 1'b0;
    tx = 1'b0;
    w0 = 16'h0000;
    w1 = 11'h000;
    word = 26'h0000000;
    ad = 8'h00;
    rng = RANGE0;
  end
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      act = 1'b1;
      tx = 1'b0;
      rdm = 1'b0;
      hib = 1'b1;
      ph = 0;
      cnt = -1;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      act = 1'b0;
      tx = 1'b0;
      sda_oe = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (act && cnt >= 0 && cnt < 8 && !tx) sh = {sh[6:0], sda};
    if (act && cnt == 8) mack = !sda;
  end
  always @(negedge scl) begin
    if (act) begin
      if (cnt == 7) begin
        cnt = 8;
        sda_oe = 1'b0;
        if (!tx) begin
          if (ph == 0) begin
            rdm = !sh[0];
            if (sh[7:1] != DEV) act = 1'b0;
          end else if (ph == 1) begin
            ad = sh;
          end else if (hib) begin
            hb = sh;
          end else begin
            case (ad)
              8'h00: w0 = {hb, sh};
              8'h01: w1 = {hb[2:0], sh};
              8'h02: rng = sh[3:0];
              default: ;
            endcase
            if (ad == 8'h01) word = {hb[1:0], sh, w0};
            ad = ad + 8'h01;
          end
          if (ph >= 2) hib = !hib;
          sda_oe = act;
        end
      end else if (cnt == 8) begin
        cnt = 0;
        // acked word releases, else keep sending
        if (tx && hib && mack) act = 1'b0;
        if (ph == 0 && rdm) tx = 1'b1;
        ph++;
        if (act && tx) begin
          tw = rv(ad);
          tb = hib ? tw[15:8] : tw[7:0];
          if (!hib) ad = ad + 8'h01;
          hib = !hib;
        end
        sda_oe = act && tx && !tb[7];
      end else begin
        cnt++;
        sda_oe = tx && !tb[7 - cnt];
      end
    end
  end
endmodule // opi_dev_model

// file: dv/opi_i2c_host_chk.sv
// Protocol checker bound to the ports of the two-wire host.
// Assumes ce held high, so every clock edge counts.
module opi_i2c_host_chk (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  input logic awready,
  input wire wvalid,
  input logic wready,
  input logic [1:0] bresp,
  input logic bvalid,
  input wire bready,
  input wire arvalid,
  input logic arready,
  input logic [31:0] rdata,
  input logic rvalid,
  input wire rready,
  input logic scl_o,
  input logic scl_oe,
  input logic sda_o,
  input logic sda_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_both_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_frame_start;
    $rose(sda_oe) && !scl_oe;
  endsequence
  sequence s_frame_stop;
    $fell(sda_oe) && !scl_oe;
  endsequence
  sequence s_clock_up;
    !scl_oe [*3];
  endsequence
  a_write_answer: assert property (s_both_taken |-> ##[1:2] bvalid)
    else $error("write response late");
  a_write_stands: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_write_busy: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while answering");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  a_read_stands: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read response dropped");
  a_read_busy: assert property (rvalid |-> !arready)
    else $error("read accepted while answering");
  a_open_drain: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  a_data_stable: assert property (
    $fell(scl_oe) |-> $stable(sda_oe) [*5])
    else $error("data moved while clock high");
  a_start_hold: assert property (
    s_frame_start |=> s_clock_up ##[1:8] scl_oe)
    else $error("start condition malformed");
  a_stop_idle: assert property (
    s_frame_stop |=> (!scl_oe && !sda_oe) [*3])
    else $error("bus not idle after stop");
endmodule // opi_i2c_host_chk

bind opi_i2c_host opi_i2c_host_chk chk_u (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
  .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .scl_o, .scl_oe,
  .sda_o, .sda_oe
);

// file: dv/opi_i2c_host_tb_top.sv
// Bench top: AXI4-Lite tasks drive the host, a device model answers.
// Assumes pull-ups on both lines, formed by the wired expressions.
`include "opi_defines.svh"

module opi_i2c_host_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] RANGE0 = 4'h5;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, m_oe;
  logic scl_o, sda_o, scl_oe, sda_oe;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [6:0] dev;
  int num_errors, tests_run;
  int ppm [16] = '{625, 1000, 1250, 2500, 5000, 8000, 10000, 12500,
    15000, 20000, 40000, 60000, 80000, 120000, 160000, 320000};
  wire scl = !scl_oe;
  wire sda = !(sda_oe || m_oe);

  opi_i2c_host dut_u (
    .aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .scl_i(scl),
    .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe
  );
  opi_dev_model #(.DEV(7'h60), .RANGE0(RANGE0)) m_u (
    .scl, .sda, .sda_oe(m_oe)
  );

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic stop_test();
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    logic aw_on, w_on;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw_on = 1'b1;
    w_on = 1'b1;
    while (aw_on || w_on) begin
      @(posedge aclk);
      if (aw_on && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_on = 1'b0;
      end
      if (w_on && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_on = 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // One framed transfer, then its status and the word read back
  task automatic op(input logic rd, input logic two, input logic [7:0] ra,
      input logic [31:0] wd, input logic [2:0] est, output logic [31:0] q);
    logic [31:0] st;
    logic [1:0] r;
    axw(`OPI_OFF_ADDR, {16'h0000, ra, 1'b0, dev}, r);
    axw(`OPI_OFF_WDATA, wd, r);
    axw(`OPI_OFF_CTRL, {29'h0000_0000, two, rd, 1'b1}, r);
    st = 32'h0000_0000;
    while (st[1] !== 1'b1) axr(`OPI_OFF_STATUS, st, r);
    chk({29'h0000_0000, st[2:0]}, {29'h0000_0000, est});
    axr(`OPI_OFF_RDATA, q, r);
    q = {16'h0000, q[15:0]};
  endtask

  initial begin
    #3_600_000;
    num_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    logic [31:0] q;
    logic [1:0] r;
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    dev = 7'h60;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(`OPI_OFF_ADDR, q, r);
    chk(q, `OPI_ADDR_RST);
    axr(`OPI_OFF_CTRL, q, r);
    chk(q, `OPI_CTRL_RST);
    axr(8'h18, q, r);
    chk({30'h0000_0000, r}, {30'h0000_0000, `OPI_RESP_SLVERR});
    axw(8'h18, 32'hFFFF_FFFF, r);
    chk({30'h0000_0000, r}, {30'h0000_0000, `OPI_RESP_SLVERR});
    op(1'b1, 1'b0, 8'h02, 32'h0000_0000, 3'h2, q);
    chk(q, {28'h0000_000, RANGE0});
    op(1'b0, 1'b0, 8'h02, 32'h0000_FFF3, 3'h2, q);
    op(1'b1, 1'b0, 8'h02, 32'h0000_0000, 3'h2, q);
    chk(q, 32'h0000_0003);
    for (int i = 0; i < 16; i++) begin
      op(1'b0, 1'b0, 8'h02, 32'(i), 3'h2, q);
      op(1'b1, 1'b0, 8'h02, 32'h0000_0000, 3'h2, q);
      chk(q, 32'(i));
      axr(`OPI_OFF_RANGE, q, r);
      chk(q, 32'(ppm[i]));
    end
    op(1'b0, 1'b1, 8'h00, 32'h8765_1234, 3'h2, q);
    // Settle flag rises after the high part lands, then drops
    axr(`OPI_OFF_STATUS, q, r);
    chk(q, (32'h0000_0001 << `OPI_STAT_SETTLE) |
      (32'h0000_0001 << `OPI_STAT_DONE));
    repeat (`OPI_SETTLE_CYC) @(posedge aclk);
    axr(`OPI_OFF_STATUS, q, r);
    chk(q, 32'h0000_0001 << `OPI_STAT_DONE);
    op(1'b1, 1'b0, 8'h00, 32'h0000_0000, 3'h2, q);
    chk(q, 32'h0000_1234);
    op(1'b1, 1'b0, 8'h01, 32'h0000_0000, 3'h2, q);
    chk(q, 32'h0000_0765);
    op(1'b0, 1'b1, 8'hFF, 32'hA5C3_0F0F, 3'h2, q);
    op(1'b1, 1'b0, 8'hFF, 32'h0000_0000, 3'h2, q);
    chk(q, 32'h0000_0000);
    op(1'b1, 1'b0, 8'h00, 32'h0000_0000, 3'h2, q);
    chk(q, 32'h0000_A5C3);
    dev = 7'h61;
    op(1'b0, 1'b0, 8'h00, 32'h0000_0000, 3'h6, q);
    dev = 7'h60;
    op(1'b1, 1'b0, 8'h00, 32'h0000_0000, 3'h2, q);
    chk(q, 32'h0000_A5C3);
    stop_test();
  end
endmodule // opi_i2c_host_tb_top

// file: shared/opi_defines.svh
// Constants of the two-wire host for the pulled oscillator.
// Assumes a 25 MHz aclk and 8-bit byte addresses on the AXI4-Lite side.
`ifndef OPI_DEFINES_SVH
`define OPI_DEFINES_SVH

`define OPI_CLK_PERIOD_NS 40
`define OPI_SCL_MIN_PERIOD_NS 1000
`define OPI_QTR_CYC ((`OPI_SCL_MIN_PERIOD_NS + 4 * `OPI_CLK_PERIOD_NS - 1) \
  / (4 * `OPI_CLK_PERIOD_NS))
`define OPI_SETTLE_US 30
`define OPI_SETTLE_CYC (`OPI_SETTLE_US * 1000 / `OPI_CLK_PERIOD_NS)

`define OPI_OFF_CTRL 8'h00
`define OPI_OFF_ADDR 8'h04
`define OPI_OFF_WDATA 8'h08
`define OPI_OFF_STATUS 8'h0C
`define OPI_OFF_RDATA 8'h10
`define OPI_OFF_RANGE 8'h14

`define OPI_CTRL_GO 0
`define OPI_CTRL_RD 1
`define OPI_CTRL_TWO 2
`define OPI_STAT_BUSY 0
`define OPI_STAT_DONE 1
`define OPI_STAT_NACK 2
`define OPI_STAT_SETTLE 3

`define OPI_CTRL_RST 32'h0000_0000
`define OPI_ADDR_RST 32'h0000_0060
`define OPI_WDATA_RST 32'h0000_0000

`define OPI_DIR_READ 1'b0
`define OPI_DIR_WRITE 1'b1
`define OPI_REG_WORD_LOW 8'h00
`define OPI_REG_WORD_HIGH 8'h01
`define OPI_REG_PULL_RANGE 8'h02

`define OPI_RESP_OKAY 2'h0
`define OPI_RESP_SLVERR 2'h2

`endif

// file: shared/opi_pkg.sv
// Types of the two-wire host for the pulled oscillator.
// Assumes opi_defines.svh for all numeric constants.
package opi_pkg;

  typedef enum logic [2:0] {
    OPI_ST_IDLE = 3'h0,
    OPI_ST_LOAD = 3'h1,
    OPI_ST_START = 3'h2,
    OPI_ST_BIT = 3'h3,
    OPI_ST_STOP = 3'h4
  } opi_state_type;

  typedef enum logic [1:0] {
    OPI_OP_START = 2'h0,
    OPI_OP_TX = 2'h1,
    OPI_OP_RX = 2'h2,
    OPI_OP_STOP = 2'h3
  } opi_op_type;

  typedef struct packed {
    logic rd;
    logic two;
    logic [6:0] dev;
    logic [7:0] regad;
    logic [31:0] data;
  } opi_req_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } opi_pins_type;

  typedef struct packed {
    opi_op_type op;
    logic [7:0] tx;
  } opi_step_type;

endpackage
